// ==== src/scrb_pkg.sv ====
// constants for the system control register bank
// assumes byte-wide indexed CRT port access, one system clock
package scrb_pkg;

  // crt index/data port addresses, mono and colour mappings
  localparam logic [15:0] IO_INDEX_MONO = 16'h03B4;
  localparam logic [15:0] IO_DATA_MONO = 16'h03B5;
  localparam logic [15:0] IO_INDEX_COLOR = 16'h03D4;
  localparam logic [15:0] IO_DATA_COLOR = 16'h03D5;

  // register indices
  localparam logic [7:0] IDX_UNLOCK_KEY = 8'h39;
  localparam logic [7:0] IDX_BANK_FIRST = 8'h40;
  localparam logic [7:0] IDX_BANK_LAST = 8'h4F;
  localparam logic [7:0] IDX_SYS_CFG = 8'h40;
  localparam logic [7:0] IDX_SCRATCH = 8'h41;
  localparam logic [7:0] IDX_MODE_CTL = 8'h42;
  localparam logic [7:0] IDX_EXT_MODE = 8'h43;
  localparam logic [7:0] IDX_CUR_MODE = 8'h45;
  localparam logic [7:0] IDX_ORG_X_LO = 8'h46;
  localparam logic [7:0] IDX_ORG_X_HI = 8'h47;
  localparam logic [7:0] IDX_ORG_Y_LO = 8'h48;
  localparam logic [7:0] IDX_ORG_Y_HI = 8'h49;
  localparam logic [7:0] IDX_FG_STACK = 8'h4A;
  localparam logic [7:0] IDX_BG_STACK = 8'h4B;
  localparam logic [7:0] IDX_START_LO = 8'h4C;
  localparam logic [7:0] IDX_START_HI = 8'h4D;
  localparam logic [7:0] IDX_OFF_X = 8'h4E;
  localparam logic [7:0] IDX_OFF_Y = 8'h4F;

  // field positions and widths
  localparam int SYS_CFG_ENH_BIT = 0;
  localparam int SYS_CFG_WAIT_BIT = 4;
  localparam int MODE_INTERLACE_BIT = 5;
  localparam int EXT_WIDTH_B8_BIT = 2;
  localparam int EXT_HDOUBLE_BIT = 7;
  localparam int CUR_EN_BIT = 0;
  localparam int CUR_SPACE_BIT = 4;
  localparam int ORIGIN_W = 11;
  localparam int START_W = 13;
  localparam int OFFSET_W = 6;
  localparam logic [1:0] STACK_LAST = 2'h2;

  // reset and answer values
  localparam logic [7:0] RST_SYS_CFG = 8'h20;
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [7:0] RST_KEY = 8'h00;
  // arbitrary unlock key value
  localparam logic [7:0] UNLOCK_KEY = 8'hA5;
  localparam logic [7:0] LOCKED_READ = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

// ==== src/scrb_top.sv ====
// system control register bank behind the indexed crt port
// assumes host i/o strobes synchronous to i_clock, one access per cycle
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - reset locks bank against reads and writes
// - matching key in lock register grants access
// - stays open until key changes away
// - data port 3B5 mono, 3D5 colour
// - config bit0 enhanced access, bit5 reserved one
// - config bit4 local bus wait states
// - index 41 plain firmware scratch byte
// - mode control bit5 selects interlace
// - extended mode bit2 legacy width bit8
// - extended mode bit7 horizontal counter double
// - cursor mode bit0 cursor on/off
// - cursor mode bit4 reserves right-side space
// - 46-47 hold 11-bit cursor x origin
// - 48-49 hold 11-bit cursor y origin
// - 4A three-deep foreground colour stack
// - 4B three-deep background colour stack
// - 4C-4D hold 13-bit pattern start address
// - 4E holds 6-bit pattern x offset
// - 4F holds 6-bit pattern y offset
// - 8-bit key register gates the bank
module scrb_top (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // host i/o port
  input wire logic i_color_map,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_rd_hit,
  // bank state
  output logic o_unlocked,
  // mode controls
  output logic o_enhanced_access_en,
  output logic o_ready_wait_ctl,
  output logic o_interlace,
  output logic o_screen_width_b8,
  output logic o_hcount_double,
  // cursor controls
  output logic o_cursor_en,
  output logic o_cursor_right_space,
  output logic [10:0] o_cursor_x,
  output logic [10:0] o_cursor_y,
  output logic [23:0] o_cursor_fg,
  output logic [23:0] o_cursor_bg,
  output logic [12:0] o_cursor_start,
  output logic [5:0] o_cursor_off_x,
  output logic [5:0] o_cursor_off_y
);

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] key;
    logic unlocked;
    logic [7:0] sys_cfg;
    logic [7:0] scratch;
    logic [7:0] mode_ctl;
    logic [7:0] ext_mode;
    logic [7:0] cur_mode;
    logic [15:0] org_x;
    logic [15:0] org_y;
    logic [2:0][7:0] fg;
    logic [2:0][7:0] bg;
    logic [1:0] fg_ptr;
    logic [1:0] bg_ptr;
    logic [15:0] start;
    logic [7:0] off_x;
    logic [7:0] off_y;
    logic [7:0] rdata;
    logic rd_hit;
  } scrb_state_t;

  scrb_state_t st;
  scrb_state_t next_st;

  logic idx_sel;
  logic dat_sel;
  logic in_bank;
  logic wr_index;
  logic rd_index;
  logic wr_data;
  logic rd_data;

  // port decode follows the mono/colour mapping
  assign idx_sel = (i_io_addr == (i_color_map ? scrb_pkg::IO_INDEX_COLOR
                                              : scrb_pkg::IO_INDEX_MONO));
  assign dat_sel = (i_io_addr == (i_color_map ? scrb_pkg::IO_DATA_COLOR
                                              : scrb_pkg::IO_DATA_MONO));
  assign in_bank = (st.index >= scrb_pkg::IDX_BANK_FIRST) &&
                   (st.index <= scrb_pkg::IDX_BANK_LAST);
  assign wr_index = i_io_wr && idx_sel;
  assign rd_index = i_io_rd && idx_sel;
  assign wr_data = i_io_wr && dat_sel;
  assign rd_data = i_io_rd && dat_sel;

  function automatic logic [1:0] step_ptr(input logic [1:0] ptr);
    step_ptr = (ptr == scrb_pkg::STACK_LAST) ? 2'h0 : ptr + 2'h1;
  endfunction

  function automatic logic [7:0] bank_read(input scrb_state_t s);
    case (s.index)
      scrb_pkg::IDX_SYS_CFG: bank_read = s.sys_cfg;
      scrb_pkg::IDX_SCRATCH: bank_read = s.scratch;
      scrb_pkg::IDX_MODE_CTL: bank_read = s.mode_ctl;
      scrb_pkg::IDX_EXT_MODE: bank_read = s.ext_mode;
      scrb_pkg::IDX_CUR_MODE: bank_read = s.cur_mode;
      scrb_pkg::IDX_ORG_X_LO: bank_read = s.org_x[7:0];
      scrb_pkg::IDX_ORG_X_HI: bank_read = s.org_x[15:8];
      scrb_pkg::IDX_ORG_Y_LO: bank_read = s.org_y[7:0];
      scrb_pkg::IDX_ORG_Y_HI: bank_read = s.org_y[15:8];
      scrb_pkg::IDX_FG_STACK: bank_read = s.fg[s.fg_ptr];
      scrb_pkg::IDX_BG_STACK: bank_read = s.bg[s.bg_ptr];
      scrb_pkg::IDX_START_LO: bank_read = s.start[7:0];
      scrb_pkg::IDX_START_HI: bank_read = s.start[15:8];
      scrb_pkg::IDX_OFF_X: bank_read = s.off_x;
      scrb_pkg::IDX_OFF_Y: bank_read = s.off_y;
      default: bank_read = scrb_pkg::UNMAPPED_READ;
    endcase
  endfunction

  always_comb begin
    next_st = st;
    next_st.rd_hit = 1'b0;
    if (wr_index) begin
      next_st.index = i_io_wdata;
    end
    if (rd_index) begin
      next_st.rd_hit = 1'b1;
      next_st.rdata = st.index;
    end
    // key register is always reachable
    if (dat_sel && st.index == scrb_pkg::IDX_UNLOCK_KEY) begin
      if (i_io_wr) begin
        next_st.key = i_io_wdata;
        next_st.unlocked = (i_io_wdata == scrb_pkg::UNLOCK_KEY);
      end
      if (i_io_rd) begin
        next_st.rd_hit = 1'b1;
        next_st.rdata = st.key;
      end
    end
    if (dat_sel && in_bank) begin
      if (i_io_rd) begin
        next_st.rd_hit = 1'b1;
        next_st.rdata = st.unlocked ? bank_read(st) : scrb_pkg::LOCKED_READ;
      end
      if (st.unlocked && (i_io_rd || i_io_wr)) begin
        if (st.index == scrb_pkg::IDX_FG_STACK) begin
          next_st.fg_ptr = step_ptr(st.fg_ptr);
        end
        if (st.index == scrb_pkg::IDX_BG_STACK) begin
          next_st.bg_ptr = step_ptr(st.bg_ptr);
        end
        if (i_io_rd && st.index == scrb_pkg::IDX_CUR_MODE) begin
          next_st.fg_ptr = 2'h0;
          next_st.bg_ptr = 2'h0;
        end
      end
      // writes land only while the key is held
      if (st.unlocked && i_io_wr) begin
        case (st.index)
          scrb_pkg::IDX_SYS_CFG: next_st.sys_cfg = i_io_wdata;
          scrb_pkg::IDX_SCRATCH: next_st.scratch = i_io_wdata;
          scrb_pkg::IDX_MODE_CTL: next_st.mode_ctl = i_io_wdata;
          scrb_pkg::IDX_EXT_MODE: next_st.ext_mode = i_io_wdata;
          scrb_pkg::IDX_CUR_MODE: next_st.cur_mode = i_io_wdata;
          scrb_pkg::IDX_ORG_X_LO: next_st.org_x[7:0] = i_io_wdata;
          scrb_pkg::IDX_ORG_X_HI: next_st.org_x[15:8] = i_io_wdata;
          scrb_pkg::IDX_ORG_Y_LO: next_st.org_y[7:0] = i_io_wdata;
          scrb_pkg::IDX_ORG_Y_HI: next_st.org_y[15:8] = i_io_wdata;
          scrb_pkg::IDX_FG_STACK: next_st.fg[st.fg_ptr] = i_io_wdata;
          scrb_pkg::IDX_BG_STACK: next_st.bg[st.bg_ptr] = i_io_wdata;
          scrb_pkg::IDX_START_LO: next_st.start[7:0] = i_io_wdata;
          scrb_pkg::IDX_START_HI: next_st.start[15:8] = i_io_wdata;
          scrb_pkg::IDX_OFF_X: next_st.off_x = i_io_wdata;
          scrb_pkg::IDX_OFF_Y: next_st.off_y = i_io_wdata;
          default: next_st.index = st.index;
        endcase
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st.index <= 8'h00;
      st.key <= scrb_pkg::RST_KEY;
      st.unlocked <= 1'b0;
      st.sys_cfg <= scrb_pkg::RST_SYS_CFG;
      st.scratch <= scrb_pkg::RST_REG8;
      st.mode_ctl <= scrb_pkg::RST_REG8;
      st.ext_mode <= scrb_pkg::RST_REG8;
      st.cur_mode <= scrb_pkg::RST_REG8;
      st.org_x <= scrb_pkg::RST_REG16;
      st.org_y <= scrb_pkg::RST_REG16;
      st.fg <= '0;
      st.bg <= '0;
      st.fg_ptr <= 2'h0;
      st.bg_ptr <= 2'h0;
      st.start <= scrb_pkg::RST_REG16;
      st.off_x <= scrb_pkg::RST_REG8;
      st.off_y <= scrb_pkg::RST_REG8;
      st.rdata <= 8'h00;
      st.rd_hit <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign o_io_rdata = st.rdata;
  assign o_io_rd_hit = st.rd_hit;
  assign o_unlocked = st.unlocked;
  assign o_enhanced_access_en = st.sys_cfg[scrb_pkg::SYS_CFG_ENH_BIT];
  assign o_ready_wait_ctl = st.sys_cfg[scrb_pkg::SYS_CFG_WAIT_BIT];
  assign o_interlace = st.mode_ctl[scrb_pkg::MODE_INTERLACE_BIT];
  assign o_screen_width_b8 = st.ext_mode[scrb_pkg::EXT_WIDTH_B8_BIT];
  assign o_hcount_double = st.ext_mode[scrb_pkg::EXT_HDOUBLE_BIT];
  assign o_cursor_en = st.cur_mode[scrb_pkg::CUR_EN_BIT];
  assign o_cursor_right_space = st.cur_mode[scrb_pkg::CUR_SPACE_BIT];
  assign o_cursor_x = st.org_x[scrb_pkg::ORIGIN_W-1:0];
  assign o_cursor_y = st.org_y[scrb_pkg::ORIGIN_W-1:0];
  assign o_cursor_fg = st.fg;
  assign o_cursor_bg = st.bg;
  assign o_cursor_start = st.start[scrb_pkg::START_W-1:0];
  assign o_cursor_off_x = st.off_x[scrb_pkg::OFFSET_W-1:0];
  assign o_cursor_off_y = st.off_y[scrb_pkg::OFFSET_W-1:0];

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_key_unlock;
    wr_data && st.index == scrb_pkg::IDX_UNLOCK_KEY && i_io_wdata == scrb_pkg::UNLOCK_KEY;
  endsequence

  sequence s_scratch_write;
    wr_data && !i_io_rd && st.index == scrb_pkg::IDX_SCRATCH;
  endsequence

  property p_locked_write_ignored;
    wr_data && in_bank && !st.unlocked |=> $stable(st.scratch) && $stable(st.cur_mode);
  endproperty
  a_locked_write_ignored: assert property (p_locked_write_ignored)
    else $error("bank changed while locked");

  property p_locked_read_blocked;
    rd_data && in_bank && !st.unlocked |=> o_io_rd_hit && o_io_rdata == scrb_pkg::LOCKED_READ;
  endproperty
  a_locked_read_blocked: assert property (p_locked_read_blocked)
    else $error("locked read returned bank data");

  property p_unlock_then_write;
    s_key_unlock ##1 (!wr_data)[*3] ##1 s_scratch_write |=> st.scratch == $past(i_io_wdata);
  endproperty
  a_unlock_then_write: assert property (p_unlock_then_write)
    else $error("write after unlock not taken");

  property p_unlock_follows_key;
    wr_data && st.index == scrb_pkg::IDX_UNLOCK_KEY |=>
      o_unlocked == ($past(i_io_wdata) == scrb_pkg::UNLOCK_KEY);
  endproperty
  a_unlock_follows_key: assert property (p_unlock_follows_key)
    else $error("unlock state disagrees with key");

  property p_stays_unlocked;
    st.unlocked && !(wr_data && st.index == scrb_pkg::IDX_UNLOCK_KEY) |=> st.unlocked;
  endproperty
  a_stays_unlocked: assert property (p_stays_unlocked)
    else $error("bank relocked without key change");

  property p_index_port;
    wr_index |=> st.index == $past(i_io_wdata);
  endproperty
  a_index_port: assert property (p_index_port)
    else $error("index port write lost");

  property p_interlace_write;
    wr_data && st.unlocked && st.index == scrb_pkg::IDX_MODE_CTL |=>
      o_interlace == $past(i_io_wdata[5]);
  endproperty
  a_interlace_write: assert property (p_interlace_write)
    else $error("interlace bit not updated");

  property p_scratch_read;
    rd_data && !i_io_wr && st.unlocked && st.index == scrb_pkg::IDX_SCRATCH |=>
      o_io_rd_hit && o_io_rdata == $past(st.scratch);
  endproperty
  a_scratch_read: assert property (p_scratch_read)
    else $error("scratch read mismatch");

  property p_x_high_byte;
    wr_data && st.unlocked && st.index == scrb_pkg::IDX_ORG_X_HI |=>
      o_cursor_x[10:8] == $past(i_io_wdata[2:0]);
  endproperty
  a_x_high_byte: assert property (p_x_high_byte)
    else $error("cursor x high byte misplaced");

  property p_fg_wrap;
    (i_io_rd || i_io_wr) && dat_sel && st.unlocked && st.index == scrb_pkg::IDX_FG_STACK &&
      st.fg_ptr == 2'h2 |=> st.fg_ptr == 2'h0;
  endproperty
  a_fg_wrap: assert property (p_fg_wrap)
    else $error("foreground pointer did not wrap");

  property p_ptr_clear;
    rd_data && st.unlocked && st.index == scrb_pkg::IDX_CUR_MODE |=>
      st.fg_ptr == 2'h0 && st.bg_ptr == 2'h0;
  endproperty
  a_ptr_clear: assert property (p_ptr_clear)
    else $error("stack pointers not cleared");

  property p_enhanced_write;
    wr_data && st.unlocked && st.index == scrb_pkg::IDX_SYS_CFG |=>
      o_enhanced_access_en == $past(i_io_wdata[scrb_pkg::SYS_CFG_ENH_BIT]);
  endproperty
  a_enhanced_write: assert property (p_enhanced_write)
    else $error("enhanced access bit not updated");

  property p_wait_state_write;
    wr_data && st.unlocked && st.index == scrb_pkg::IDX_SYS_CFG |=>
      o_ready_wait_ctl == $past(i_io_wdata[scrb_pkg::SYS_CFG_WAIT_BIT]);
  endproperty
  a_wait_state_write: assert property (p_wait_state_write)
    else $error("wait state bit not updated");

  property p_width_b8_write;
    wr_data && st.unlocked && st.index == scrb_pkg::IDX_EXT_MODE |=>
      o_screen_width_b8 == $past(i_io_wdata[scrb_pkg::EXT_WIDTH_B8_BIT]);
  endproperty
  a_width_b8_write: assert property (p_width_b8_write)
    else $error("screen width bit 8 not updated");

  property p_hdouble_write;
    wr_data && st.unlocked && st.index == scrb_pkg::IDX_EXT_MODE |=>
      o_hcount_double == $past(i_io_wdata[scrb_pkg::EXT_HDOUBLE_BIT]);
  endproperty
  a_hdouble_write: assert property (p_hdouble_write)
    else $error("counter double bit not updated");

  property p_cursor_en_write;
    wr_data && st.unlocked && st.index == scrb_pkg::IDX_CUR_MODE |=>
      o_cursor_en == $past(i_io_wdata[scrb_pkg::CUR_EN_BIT]);
  endproperty
  a_cursor_en_write: assert property (p_cursor_en_write)
    else $error("cursor enable not updated");

  property p_start_high_byte;
    wr_data && st.unlocked && st.index == scrb_pkg::IDX_START_HI |=>
      o_cursor_start[12:8] == $past(i_io_wdata[4:0]);
  endproperty
  a_start_high_byte: assert property (p_start_high_byte)
    else $error("pattern start high byte misplaced");

  property p_off_x_write;
    wr_data && st.unlocked && st.index == scrb_pkg::IDX_OFF_X |=>
      o_cursor_off_x == $past(i_io_wdata[5:0]);
  endproperty
  a_off_x_write: assert property (p_off_x_write)
    else $error("pattern x offset not updated");

  property p_locked_ptr_hold;
    dat_sel && in_bank && !st.unlocked |=> $stable(st.fg_ptr) && $stable(st.bg_ptr);
  endproperty
  a_locked_ptr_hold: assert property (p_locked_ptr_hold)
    else $error("stack pointer moved while locked");

  property p_foreign_port_quiet;
    i_io_rd && !idx_sel && !dat_sel |=> !o_io_rd_hit;
  endproperty
  a_foreign_port_quiet: assert property (p_foreign_port_quiet)
    else $error("read answered on an unmapped port");

endmodule

`default_nettype wire

// ==== test/scrb_tb_top.sv ====
// self-checking bench for the system control register bank
// assumes scrb_top and scrb_pkg as delivered, 25 MHz clock, bench drives on falling edge
`timescale 1ns/1ps
`default_nettype none
module scrb_tb_top;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [3:0] sel;
    logic [23:0] exp;
  } scrb_row_t;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_color_map = 1'b1;
  logic [15:0] i_io_addr = 16'h0000;
  logic i_io_wr = 1'b0;
  logic i_io_rd = 1'b0;
  logic [7:0] i_io_wdata = 8'h00;
  logic [7:0] o_io_rdata;
  logic o_io_rd_hit, o_unlocked, o_enhanced_access_en, o_ready_wait_ctl, o_interlace;
  logic o_screen_width_b8, o_hcount_double, o_cursor_en, o_cursor_right_space;
  logic [10:0] o_cursor_x, o_cursor_y;
  logic [23:0] o_cursor_fg, o_cursor_bg;
  logic [12:0] o_cursor_start;
  logic [5:0] o_cursor_off_x, o_cursor_off_y;
  int fail_count = 0;
  int checked = 0;
  scrb_row_t rows [17];

  always #20 i_clock = ~i_clock;

  scrb_top uut (.i_clock(i_clock), .i_rst(i_rst), .i_color_map(i_color_map),
    .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
    .o_io_rdata(o_io_rdata), .o_io_rd_hit(o_io_rd_hit), .o_unlocked(o_unlocked),
    .o_enhanced_access_en(o_enhanced_access_en), .o_ready_wait_ctl(o_ready_wait_ctl),
    .o_interlace(o_interlace), .o_screen_width_b8(o_screen_width_b8),
    .o_hcount_double(o_hcount_double), .o_cursor_en(o_cursor_en),
    .o_cursor_right_space(o_cursor_right_space), .o_cursor_x(o_cursor_x),
    .o_cursor_y(o_cursor_y), .o_cursor_fg(o_cursor_fg), .o_cursor_bg(o_cursor_bg),
    .o_cursor_start(o_cursor_start), .o_cursor_off_x(o_cursor_off_x),
    .o_cursor_off_y(o_cursor_off_y));

  // control output group picked by a row
  function automatic logic [23:0] view(input logic [3:0] sel);
    case (sel)
      4'h0: return 24'({o_ready_wait_ctl, o_enhanced_access_en});
      4'h1: return 24'({o_ready_wait_ctl, o_enhanced_access_en, o_interlace, o_hcount_double,
                        o_screen_width_b8, o_cursor_right_space, o_cursor_en});
      4'h2: return 24'(o_interlace);
      4'h3: return 24'({o_hcount_double, o_screen_width_b8});
      4'h4: return 24'({o_cursor_right_space, o_cursor_en});
      4'h5: return 24'(o_cursor_x);
      4'h6: return 24'(o_cursor_y);
      4'h7: return 24'(o_cursor_start);
      4'h8: return 24'(o_cursor_off_x);
      4'h9: return 24'(o_cursor_off_y);
      default: return 24'h000000;
    endcase
  endfunction

  function automatic logic [15:0] iport();
    return i_color_map ? scrb_pkg::IO_INDEX_COLOR : scrb_pkg::IO_INDEX_MONO;
  endfunction

  function automatic logic [15:0] dport();
    return i_color_map ? scrb_pkg::IO_DATA_COLOR : scrb_pkg::IO_DATA_MONO;
  endfunction

  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic port_wr(input logic [15:0] addr, input logic [7:0] data);
    @(negedge i_clock);
    i_io_addr = addr;
    i_io_wdata = data;
    i_io_wr = 1'b1;
    @(negedge i_clock);
    i_io_wr = 1'b0;
  endtask

  // answer lands on the taking edge, checked at the next falling edge
  task automatic port_rd(input logic [15:0] addr, input logic hit, input logic [7:0] exp);
    @(negedge i_clock);
    i_io_addr = addr;
    i_io_rd = 1'b1;
    @(negedge i_clock);
    i_io_rd = 1'b0;
    check("read hit", 24'(hit), 24'(o_io_rd_hit));
    if (hit) begin
      check("read data", 24'(exp), 24'(o_io_rdata));
    end
  endtask

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] data);
    port_wr(iport(), idx);
    port_wr(dport(), data);
  endtask

  task automatic reg_rd(input logic [7:0] idx, input logic hit, input logic [7:0] exp);
    port_wr(iport(), idx);
    port_rd(dport(), hit, exp);
  endtask

  task automatic give_verdict();
    $display("counts checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clock);
    fail_count++;
    $display("mismatch watchdog expected finish seen timeout");
    give_verdict();
  end

  initial begin
    rows = '{
      '{8'h40, 8'h31, 4'h0, 24'h000003},
      '{8'h40, 8'h20, 4'h0, 24'h000000},
      '{8'h41, 8'h5A, 4'h1, 24'h000000},
      '{8'h42, 8'h20, 4'h2, 24'h000001},
      '{8'h42, 8'hDF, 4'h2, 24'h000000},
      '{8'h43, 8'h84, 4'h3, 24'h000003},
      '{8'h43, 8'h7B, 4'h3, 24'h000000},
      '{8'h45, 8'h11, 4'h4, 24'h000003},
      '{8'h45, 8'hEE, 4'h4, 24'h000000},
      '{8'h46, 8'hFF, 4'h5, 24'h0000FF},
      '{8'h47, 8'hFD, 4'h5, 24'h0005FF},
      '{8'h48, 8'h34, 4'h6, 24'h000034},
      '{8'h49, 8'h07, 4'h6, 24'h000734},
      '{8'h4C, 8'hAB, 4'h7, 24'h0000AB},
      '{8'h4D, 8'hFF, 4'h7, 24'h001FAB},
      '{8'h4E, 8'hFF, 4'h8, 24'h00003F},
      '{8'h4F, 8'hC9, 4'h9, 24'h000009}};
    repeat (8) @(negedge i_clock);
    i_rst = 1'b0;
    check("unlocked", 24'h0, 24'(o_unlocked));
    reg_wr(scrb_pkg::IDX_SYS_CFG, 8'h31);
    check("enhanced", 24'h0, 24'(o_enhanced_access_en));
    reg_rd(scrb_pkg::IDX_SCRATCH, 1'b1, scrb_pkg::LOCKED_READ);
    reg_rd(scrb_pkg::IDX_UNLOCK_KEY, 1'b1, scrb_pkg::RST_KEY);
    reg_wr(scrb_pkg::IDX_UNLOCK_KEY, 8'h5A);
    check("unlocked", 24'h0, 24'(o_unlocked));
    reg_wr(scrb_pkg::IDX_UNLOCK_KEY, scrb_pkg::UNLOCK_KEY);
    check("unlocked", 24'h1, 24'(o_unlocked));
    reg_wr(scrb_pkg::IDX_SCRATCH, 8'h3C);
    reg_rd(scrb_pkg::IDX_SCRATCH, 1'b1, 8'h3C);
    reg_rd(scrb_pkg::IDX_UNLOCK_KEY, 1'b1, scrb_pkg::UNLOCK_KEY);
    $display("test reset and unlock done");
    for (int n = 0; n < 17; n++) begin
      reg_wr(rows[n].idx, rows[n].wdata);
      check("control output", rows[n].exp, view(rows[n].sel));
      reg_rd(rows[n].idx, 1'b1, rows[n].wdata);
    end
    $display("test register rows done");
    // pointers cleared by cursor mode read, then three pushes each
    reg_rd(scrb_pkg::IDX_CUR_MODE, 1'b1, 8'hEE);
    reg_wr(scrb_pkg::IDX_FG_STACK, 8'h11);
    reg_wr(scrb_pkg::IDX_FG_STACK, 8'h22);
    reg_wr(scrb_pkg::IDX_FG_STACK, 8'h33);
    check("fg stack", 24'h332211, o_cursor_fg);
    reg_wr(scrb_pkg::IDX_BG_STACK, 8'h44);
    reg_wr(scrb_pkg::IDX_BG_STACK, 8'h55);
    reg_wr(scrb_pkg::IDX_BG_STACK, 8'h66);
    check("bg stack", 24'h665544, o_cursor_bg);
    reg_wr(scrb_pkg::IDX_FG_STACK, 8'h77);
    check("fg wrap", 24'h332277, o_cursor_fg);
    reg_rd(scrb_pkg::IDX_CUR_MODE, 1'b1, 8'hEE);
    reg_rd(scrb_pkg::IDX_FG_STACK, 1'b1, 8'h77);
    reg_rd(scrb_pkg::IDX_FG_STACK, 1'b1, 8'h22);
    reg_rd(scrb_pkg::IDX_FG_STACK, 1'b1, 8'h33);
    reg_rd(scrb_pkg::IDX_FG_STACK, 1'b1, 8'h77);
    $display("test colour stacks done");
    repeat (50) @(negedge i_clock);
    check("unlocked", 24'h1, 24'(o_unlocked));
    reg_wr(scrb_pkg::IDX_UNLOCK_KEY, 8'h00);
    check("unlocked", 24'h0, 24'(o_unlocked));
    reg_wr(scrb_pkg::IDX_SCRATCH, 8'hC3);
    reg_rd(scrb_pkg::IDX_FG_STACK, 1'b1, scrb_pkg::LOCKED_READ);
    reg_wr(scrb_pkg::IDX_UNLOCK_KEY, scrb_pkg::UNLOCK_KEY);
    reg_rd(scrb_pkg::IDX_SCRATCH, 1'b1, 8'h5A);
    reg_rd(scrb_pkg::IDX_FG_STACK, 1'b1, 8'h22);
    $display("test relock done");
    @(negedge i_clock);
    i_color_map = 1'b0;
    reg_wr(scrb_pkg::IDX_SCRATCH, 8'h96);
    reg_rd(scrb_pkg::IDX_SCRATCH, 1'b1, 8'h96);
    port_rd(scrb_pkg::IO_DATA_COLOR, 1'b0, 8'h00);
    @(negedge i_clock);
    i_color_map = 1'b1;
    reg_rd(scrb_pkg::IDX_SCRATCH, 1'b1, 8'h96);
    reg_rd(8'h44, 1'b1, scrb_pkg::UNMAPPED_READ);
    reg_rd(8'h50, 1'b0, 8'h00);
    port_rd(16'h03C5, 1'b0, 8'h00);
    $display("test port mapping done");
    @(negedge i_clock);
    i_rst = 1'b1;
    @(negedge i_clock);
    i_rst = 1'b0;
    check("unlocked", 24'h0, 24'(o_unlocked));
    check("fg stack", 24'h000000, o_cursor_fg);
    reg_rd(scrb_pkg::IDX_SYS_CFG, 1'b1, scrb_pkg::LOCKED_READ);
    reg_wr(scrb_pkg::IDX_UNLOCK_KEY, scrb_pkg::UNLOCK_KEY);
    reg_rd(scrb_pkg::IDX_SYS_CFG, 1'b1, scrb_pkg::RST_SYS_CFG);
    $display("test second reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
